// File: include/counter_array_params.svh
// Offsets, field positions, reset values and limits of the counter array
`ifndef COUNTER_ARRAY_PARAMS_SVH
`define COUNTER_ARRAY_PARAMS_SVH

`define CA_NUM_MOD        6

`define CA_ADDR_CTRL      8'h00
`define CA_ADDR_MODE      8'h01
`define CA_ADDR_CNT_L     8'h02
`define CA_ADDR_CNT_H     8'h03
`define CA_ADDR_CPM_BASE  8'h10
`define CA_ADDR_CPL_BASE  8'h20
`define CA_ADDR_CPH_BASE  8'h30

`define CA_BIT_OVF        7
`define CA_BIT_RUN        6
`define CA_BIT_OVF_IE     0

`define CA_BIT_PWM16      7
`define CA_BIT_ECOM       6
`define CA_BIT_PWM        1
`define CA_BIT_ECCF       0

`define CA_CTRL_RST       8'h00
`define CA_MODE_RST       8'h00
`define CA_CPM_RST        8'h00
`define CA_CMP_RST        8'h00
`define CA_CNT_RST        16'h0000
`define CA_RDATA_RST      8'h00

`define CA_LOW_MAX        8'hff
`define CA_CNT_MAX        16'hffff
`define CA_CNT_STEP       16'h0001

`endif

// File: include/counter_array_pkg.sv
// Types shared by the counter array PWM block
package counter_array_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [15:0] word_t;
    typedef logic [5:0]  mod_vec_t;

    typedef enum logic [1:0] {
        MODE_IDLE  = 2'b00,
        MODE_PWM8  = 2'b01,
        MODE_PWM16 = 2'b10,
        MODE_TIMER = 2'b11
    } mod_mode_t;

endpackage

// File: rtl/counter_array_pwm.sv
// Counter array with six compare modules in 8-bit and 16-bit PWM modes
`timescale 1ns/1ps
`include "counter_array_params.svh"

// Function
// - 8-bit PWM: pin goes high when counter low byte equals compare low byte
// - 8-bit PWM: pin goes low when counter low byte overflows, except with a zero compare high byte
// - 8-bit PWM: compare low byte reloads from compare high byte on low wrap
// - 8-bit PWM selected by comparator enable and PWM enable, sixteen-bit select clear
// - 8-bit PWM high fraction is (256 minus compare high byte) over 256
// - 16-bit PWM: compare word counts low ticks; pin high on 16-bit match
// - 16-bit PWM: pin goes low when the 16-bit counter overflows, except with a zero compare word
// - 16-bit PWM selected by comparator enable, PWM enable and sixteen-bit select
// - 16-bit PWM high fraction is (65536 minus compare word) over 65536
// - Overflow flag, control bit 7, sets when counter wraps 0xFFFF to 0x0000
// - Interrupt request raised while overflow flag set and its interrupt enabled
// - A module's match flag sets whenever its compare match occurs
module counter_array_pwm (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_nrst,
    input  wire logic                      i_tick,
    input  wire counter_array_pkg::byte_t  i_sfr_addr,
    input  wire logic                      i_sfr_wr,
    input  wire logic                      i_sfr_rd,
    input  wire counter_array_pkg::byte_t  i_sfr_wdata,
    output logic [7:0]                     o_sfr_rdata,
    output logic [5:0]                     o_module_output_pin,
    output logic                           o_irq
);
    import counter_array_pkg::*;

    // True when addr selects module idx of a register bank at base
    function automatic logic bank_hit(
        input byte_t a,
        input byte_t base,
        input int    idx
    );
        byte_t off;
        off = idx[7:0];
        return a == byte_t'(base + off);
    endfunction

    // Mode of one module from its mode register
    function automatic mod_mode_t decode_mode(input byte_t m);
        mod_mode_t md;
        md = MODE_IDLE;
        if (m[`CA_BIT_ECOM] && m[`CA_BIT_PWM] && m[`CA_BIT_PWM16]) begin
            md = MODE_PWM16;
        end else if (m[`CA_BIT_ECOM] && m[`CA_BIT_PWM]) begin
            md = MODE_PWM8;
        end else if (m[`CA_BIT_ECOM]) begin
            // Timer decode keeps match flags alive outside the PWM modes
            md = MODE_TIMER;
        end
        return md;
    endfunction

    byte_t     ctrl_ff;
    byte_t     nxt_ctrl_ff;
    byte_t     mode_ff;
    byte_t     nxt_mode_ff;
    word_t     cnt_ff;
    word_t     nxt_cnt_ff;
    byte_t     snap_ff;
    byte_t     nxt_snap_ff;
    byte_t     rdata_ff;
    byte_t     nxt_rdata_ff;
    logic      irq_ff;
    logic      nxt_irq_ff;

    logic      cnt_write;
    logic      cnt_l_wr;
    logic      cnt_h_wr;
    logic      step;
    logic      low_wrap;
    logic      full_wrap;
    word_t     new_cnt;
    logic      ovf_req;
    logic      match_req;

    wire mod_vec_t mod_match;
    wire mod_vec_t mod_eccf;
    wire mod_vec_t mod_pin;
    wire byte_t    cpm_rd [`CA_NUM_MOD];
    wire byte_t    cpl_rd [`CA_NUM_MOD];
    wire byte_t    cph_rd [`CA_NUM_MOD];

    // ------------------------------------------------------------------
    // Counter and high-byte snapshot
    // ------------------------------------------------------------------
    // A software write to either counter byte takes the cycle; no tick
    // and no wrap event is seen then, so a reload cannot race the write.
    always_comb begin
        cnt_l_wr  = i_sfr_wr && (i_sfr_addr == `CA_ADDR_CNT_L);
        cnt_h_wr  = i_sfr_wr && (i_sfr_addr == `CA_ADDR_CNT_H);
        cnt_write = cnt_l_wr || cnt_h_wr;
        step      = ctrl_ff[`CA_BIT_RUN] && i_tick && !cnt_write;
        new_cnt   = cnt_ff + `CA_CNT_STEP;
        low_wrap  = step && (cnt_ff[7:0] == `CA_LOW_MAX);
        full_wrap = step && (cnt_ff == `CA_CNT_MAX);
    end

    always_comb begin
        nxt_cnt_ff  = cnt_ff;
        nxt_snap_ff = snap_ff;
        if (cnt_l_wr) begin
            nxt_cnt_ff[7:0] = i_sfr_wdata;
        end else if (cnt_h_wr) begin
            nxt_cnt_ff[15:8] = i_sfr_wdata;
        end else if (step) begin
            nxt_cnt_ff = new_cnt;
        end
        // Low byte read freezes the high byte so a 16-bit read is coherent
        if (i_sfr_rd && i_sfr_addr == `CA_ADDR_CNT_L) begin
            nxt_snap_ff = cnt_ff[15:8];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_ff  <= `CA_CNT_RST;
            snap_ff <= `CA_CMP_RST;
        end else begin
            cnt_ff  <= nxt_cnt_ff;
            snap_ff <= nxt_snap_ff;
        end
    end

    // ------------------------------------------------------------------
    // Compare modules
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `CA_NUM_MOD; gi = gi + 1) begin : gen_mod
            byte_t     cpm_ff;
            byte_t     nxt_cpm_ff;
            byte_t     cpl_ff;
            byte_t     nxt_cpl_ff;
            byte_t     cph_ff;
            byte_t     nxt_cph_ff;
            logic      pin_ff;
            logic      nxt_pin_ff;
            logic      match;
            byte_t     eff_cpl;
            mod_mode_t mode;

            always_comb begin
                mode = decode_mode(cpm_ff);
                // On the low wrap the freshly reloaded value is the one
                // compared, so a zero high byte gives a full-high output
                eff_cpl = (mode == MODE_PWM8 && low_wrap) ? cph_ff : cpl_ff;
                match   = 1'b0;
                if (step && mode == MODE_PWM8) begin
                    match = (new_cnt[7:0] == eff_cpl);
                end else if (step && mode != MODE_IDLE) begin
                    match = (new_cnt == {cph_ff, cpl_ff});
                end
            end

            always_comb begin
                nxt_cpm_ff = cpm_ff;
                nxt_cpl_ff = cpl_ff;
                nxt_cph_ff = cph_ff;
                nxt_pin_ff = pin_ff;
                if (i_sfr_wr && bank_hit(i_sfr_addr, `CA_ADDR_CPM_BASE, gi)) begin
                    nxt_cpm_ff = i_sfr_wdata;
                end
                // A compare word changed mid-period acts at once, so a write
                // made just after the match lands cleanly in the next period
                if (i_sfr_wr && bank_hit(i_sfr_addr, `CA_ADDR_CPH_BASE, gi)) begin
                    nxt_cph_ff = i_sfr_wdata;
                end
                // Hardware reload beats a same-cycle software write here,
                // since in this mode the low byte is owned by the reload
                if (mode == MODE_PWM8 && low_wrap) begin
                    nxt_cpl_ff = cph_ff;
                end else if (i_sfr_wr && bank_hit(i_sfr_addr, `CA_ADDR_CPL_BASE, gi)) begin
                    nxt_cpl_ff = i_sfr_wdata;
                end
                // Match wins over the wrap: low phase lasts compare ticks
                case (mode)
                    MODE_PWM8: begin
                        if (match) begin
                            nxt_pin_ff = 1'b1;
                        end else if (low_wrap) begin
                            nxt_pin_ff = 1'b0;
                        end
                    end
                    MODE_PWM16: begin
                        if (match) begin
                            nxt_pin_ff = 1'b1;
                        end else if (full_wrap) begin
                            nxt_pin_ff = 1'b0;
                        end
                    end
                    default: begin
                        nxt_pin_ff = pin_ff;
                    end
                endcase
            end

            always_ff @(posedge i_core_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    cpm_ff <= `CA_CPM_RST;
                    cpl_ff <= `CA_CMP_RST;
                    cph_ff <= `CA_CMP_RST;
                    pin_ff <= 1'b0;
                end else begin
                    cpm_ff <= nxt_cpm_ff;
                    cpl_ff <= nxt_cpl_ff;
                    cph_ff <= nxt_cph_ff;
                    pin_ff <= nxt_pin_ff;
                end
            end

            assign mod_match[gi] = match;
            assign mod_eccf[gi]  = cpm_ff[`CA_BIT_ECCF];
            assign mod_pin[gi]   = pin_ff;
            assign cpm_rd[gi]    = cpm_ff;
            assign cpl_rd[gi]    = cpl_ff;
            assign cph_rd[gi]    = cph_ff;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Control and mode registers, interrupt request
    // ------------------------------------------------------------------
    always_comb begin
        nxt_ctrl_ff = ctrl_ff;
        nxt_mode_ff = mode_ff;
        if (i_sfr_wr && i_sfr_addr == `CA_ADDR_CTRL) begin
            nxt_ctrl_ff = i_sfr_wdata;
        end
        if (i_sfr_wr && i_sfr_addr == `CA_ADDR_MODE) begin
            nxt_mode_ff = {7'h00, i_sfr_wdata[`CA_BIT_OVF_IE]};
        end
        // Hardware set is OR-ed after the write so an event never gets lost
        nxt_ctrl_ff[`CA_BIT_OVF] = nxt_ctrl_ff[`CA_BIT_OVF] | full_wrap;
        nxt_ctrl_ff[5:0]         = nxt_ctrl_ff[5:0] | mod_match;
    end

    // Match requests let software pace duty updates to the period
    always_comb begin
        ovf_req    = ctrl_ff[`CA_BIT_OVF] && mode_ff[`CA_BIT_OVF_IE];
        match_req  = |(ctrl_ff[5:0] & mod_eccf);
        nxt_irq_ff = ovf_req || match_req;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_ff <= `CA_CTRL_RST;
            mode_ff <= `CA_MODE_RST;
            irq_ff  <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl_ff;
            mode_ff <= nxt_mode_ff;
            irq_ff  <= nxt_irq_ff;
        end
    end

    // ------------------------------------------------------------------
    // Read path: data valid the cycle after the read strobe
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rdata_ff = rdata_ff;
        if (i_sfr_rd) begin
            nxt_rdata_ff = `CA_RDATA_RST;
            if (i_sfr_addr == `CA_ADDR_CTRL) begin
                nxt_rdata_ff = ctrl_ff;
            end else if (i_sfr_addr == `CA_ADDR_MODE) begin
                nxt_rdata_ff = mode_ff;
            end else if (i_sfr_addr == `CA_ADDR_CNT_L) begin
                nxt_rdata_ff = cnt_ff[7:0];
            end else if (i_sfr_addr == `CA_ADDR_CNT_H) begin
                nxt_rdata_ff = snap_ff;
            end else begin
                for (int k = 0; k < `CA_NUM_MOD; k++) begin
                    if (bank_hit(i_sfr_addr, `CA_ADDR_CPM_BASE, k)) begin
                        nxt_rdata_ff = cpm_rd[k];
                    end else if (bank_hit(i_sfr_addr, `CA_ADDR_CPL_BASE, k)) begin
                        nxt_rdata_ff = cpl_rd[k];
                    end else if (bank_hit(i_sfr_addr, `CA_ADDR_CPH_BASE, k)) begin
                        nxt_rdata_ff = cph_rd[k];
                    end
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_ff <= `CA_RDATA_RST;
        end else begin
            rdata_ff <= nxt_rdata_ff;
        end
    end

    assign o_sfr_rdata         = rdata_ff;
    assign o_module_output_pin = mod_pin;
    assign o_irq               = irq_ff;

endmodule

// File: testbench/counter_array_pwm_assertions.sv
// Port-level assertions for the counter array PWM block
`timescale 1ns/1ps
module counter_array_pwm_assertions (
    input wire logic                      i_core_clk,
    input wire logic                      i_nrst,
    input wire logic                      i_tick,
    input wire counter_array_pkg::byte_t  i_sfr_addr,
    input wire logic                      i_sfr_wr,
    input wire logic                      i_sfr_rd,
    input wire counter_array_pkg::byte_t  i_sfr_wdata,
    input wire logic [7:0]                o_sfr_rdata,
    input wire logic [5:0]                o_module_output_pin,
    input wire logic                      o_irq
);
    logic mapped;
    assign mapped = (i_sfr_addr <= 8'h03) ||
                    ((i_sfr_addr[7:4] inside {4'h1, 4'h2, 4'h3}) && (i_sfr_addr[3:0] < 4'h6));

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    chk_unmapped_read: assert property (i_sfr_rd && !mapped |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read returned nonzero data");
    chk_mode_mask: assert property (i_sfr_rd && i_sfr_addr == 8'h01 |=> o_sfr_rdata[7:1] == 7'h00)
        else $error("mode register upper bits not zero");
    chk_rdata_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
        else $error("read data changed without a read");
    chk_pin_needs_tick: assert property (!i_tick |=> $stable(o_module_output_pin))
        else $error("output pin moved without a counter step");
    chk_irq_cause: assert property ($rose(o_irq) |-> $past(i_tick, 2) || $past(i_sfr_wr, 2))
        else $error("interrupt rose without a flag event");
    chk_irq_level: assert property (o_irq && !i_sfr_wr && !$past(i_sfr_wr) |=> o_irq)
        else $error("interrupt dropped without software");
    chk_run_bit: assert property ((i_sfr_wr && i_sfr_addr == 8'h00) ##2 (i_sfr_rd && i_sfr_addr == 8'h00)
        |=> o_sfr_rdata[6] == $past(i_sfr_wdata[6], 3))
        else $error("run bit readback differs from write");
    chk_reset_quiet: assert property ($rose(i_nrst) |-> o_module_output_pin == 6'h00 && !o_irq)
        else $error("outputs not quiet after reset");
endmodule

bind counter_array_pwm counter_array_pwm_assertions i_chk (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_tick(i_tick), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .o_module_output_pin(o_module_output_pin), .o_irq(o_irq));

// File: testbench/pwm_load.sv
// Load on the module output pins: counts ticks seen with each pin high
`timescale 1ns/1ps
module pwm_load (
    input  wire logic        i_core_clk,
    input  wire logic        i_tick,
    input  wire logic        i_clear,
    input  wire logic [5:0]  i_pin,
    output logic      [15:0] o_high_cnt [6]
);
    // Sampling only on ticks gives the duty fraction in timebase units
    always @(posedge i_core_clk) begin
        for (int m = 0; m < 6; m++) begin
            if (i_clear) begin
                o_high_cnt[m] <= 16'h0000;
            end else if (i_tick && i_pin[m]) begin
                o_high_cnt[m] <= o_high_cnt[m] + 16'h0001;
            end
        end
    end
endmodule

// File: testbench/tb.sv
// Register-level test of the counter array PWM modes
`timescale 1ns/1ps
module tb;
    import counter_array_pkg::*;
    logic        i_core_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_tick = 1'b0;
    logic        i_clear = 1'b1;
    byte_t       i_sfr_addr = 8'h00;
    logic        i_sfr_wr = 1'b0;
    logic        i_sfr_rd = 1'b0;
    byte_t       i_sfr_wdata = 8'h00;
    logic [7:0]  o_sfr_rdata;
    logic [5:0]  o_module_output_pin;
    logic        o_irq;
    logic [15:0] high_cnt [6];
    int          errors = 0;
    int          n_compared = 0;

    always #12.5 i_core_clk = ~i_core_clk;

    counter_array_pwm i_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_tick(i_tick),
        .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
        .o_sfr_rdata(o_sfr_rdata), .o_module_output_pin(o_module_output_pin), .o_irq(o_irq));
    pwm_load i_load (.i_core_clk(i_core_clk), .i_tick(i_tick), .i_clear(i_clear),
        .i_pin(o_module_output_pin), .o_high_cnt(high_cnt));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Idle cycle after each access keeps strobes from being reassigned in one step
    task automatic wr(input byte_t a, input byte_t d);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'b1;
        @(negedge i_core_clk);
        i_sfr_wr = 1'b0;
        @(negedge i_core_clk);
    endtask

    task automatic rd(input byte_t a, input byte_t exp, input string what);
        i_sfr_addr = a;
        i_sfr_rd = 1'b1;
        @(negedge i_core_clk);
        i_sfr_rd = 1'b0;
        @(negedge i_core_clk);
        check(what, {8'h00, exp}, {8'h00, o_sfr_rdata});
    endtask

    task automatic ticks(input int n);
        i_tick = 1'b1;
        repeat (n) @(negedge i_core_clk);
        i_tick = 1'b0;
    endtask

    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge i_core_clk);
        errors++;
        $display("watchdog expired");
        end_sim();
    end

    initial begin
        repeat (8) @(negedge i_core_clk);
        i_nrst = 1'b1;
        i_clear = 1'b0;
        @(negedge i_core_clk);
        rd(8'h00, 8'h00, "control after reset");
        wr(8'h30, 8'hc0);
        wr(8'h10, 8'h42);
        wr(8'h21, 8'h80);
        wr(8'h31, 8'hff);
        wr(8'h11, 8'hc2);
        wr(8'h03, 8'hff);
        wr(8'h01, 8'hff);
        wr(8'h00, 8'h40);
        rd(8'h00, 8'h40, "run bit");
        $display("setup test done");
        // Counter starts at 0xff00 so one 16-bit wrap fits in the run
        ticks(512);
        check("module 0 high ticks", 16'h0040, high_cnt[0]);
        check("module 1 high ticks", 16'h0080, high_cnt[1]);
        check("pins after wrap", 16'h0000, {10'h000, o_module_output_pin});
        check("irq on overflow", 16'h0001, {15'h0000, o_irq});
        rd(8'h00, 8'hc3, "control flags");
        rd(8'h20, 8'hc0, "compare low reload");
        rd(8'h01, 8'h01, "mode register");
        $display("pwm test done");
        wr(8'h00, 8'h00);
        ticks(10);
        rd(8'h02, 8'h00, "counter low held");
        rd(8'h03, 8'h01, "counter high held");
        check("irq after clear", 16'h0000, {15'h0000, o_irq});
        rd(8'h00, 8'h00, "control cleared");
        rd(8'h04, 8'h00, "unmapped read");
        $display("hold test done");
        wr(8'h01, 8'h00);
        wr(8'h11, 8'hc3);
        wr(8'h21, 8'h10);
        wr(8'h12, 8'h40);
        wr(8'h22, 8'h20);
        wr(8'h32, 8'hff);
        wr(8'h03, 8'hff);
        wr(8'h00, 8'h40);
        ticks(16);
        @(negedge i_core_clk);
        check("irq on match", 16'h0001, {15'h0000, o_irq});
        // Duty update paced by the match interrupt, then flag cleared
        wr(8'h21, 8'hc0);
        wr(8'h00, 8'h40);
        ticks(240);
        i_clear = 1'b1;
        @(negedge i_core_clk);
        i_clear = 1'b0;
        wr(8'h03, 8'hff);
        ticks(256);
        check("module 1 high ticks after update", 16'h0040, high_cnt[1]);
        check("pins after second wrap", 16'h0000, {10'h000, o_module_output_pin});
        rd(8'h00, 8'hc7, "control after timer match");
        $display("match test done");
        end_sim();
    end
endmodule
